//--- amfs_pkg.sv
package amfs_pkg;
   // -----------------------------------------------------------------
   // general fault vector bit positions
   // -----------------------------------------------------------------
   localparam int GEN_W = 7;
   localparam int GF_LOWTEMP = 0;
   localparam int GF_AUDIO = 1;
   localparam int GF_PLL = 2;
   localparam int GF_OVP = 3;
   localparam int GF_UVP = 4;
   localparam int GF_OTE = 5;
   localparam int GF_OTW = 6;
   // -----------------------------------------------------------------
   // channel fault vector bit positions
   // -----------------------------------------------------------------
   localparam int CH_W = 3;
   localparam int CF_DC = 0;
   localparam int CF_FLY = 1;
   localparam int CF_OC = 2;
   // -----------------------------------------------------------------
   // reset values and timing
   // -----------------------------------------------------------------
   localparam logic [1:0] GAIN_RST = 2'h3;
   localparam int CLK_HZ = 200_000_000;
   localparam int DC_SINE_HZ = 1;
   localparam int DC_CYC = CLK_HZ / DC_SINE_HZ;
   localparam int BOOT_US = 100;
   localparam int BOOT_CYC = (CLK_HZ / 1_000_000) * BOOT_US;
   localparam int UNMUTE_US = 50;
   localparam int UNMUTE_CYC = (CLK_HZ / 1_000_000) * UNMUTE_US;
   localparam int RESTART_US = 100;
   localparam int RESTART_CYC = (CLK_HZ / 1_000_000) * RESTART_US;
   localparam int FSW_HI_KHZ = 256;
   localparam int FSW_LO_KHZ = 128;
   localparam int FSW_HI_DIV = CLK_HZ / (FSW_HI_KHZ * 1000);
   localparam int FSW_LO_DIV = CLK_HZ / (FSW_LO_KHZ * 1000);

   typedef enum logic [1:0] {
      AMFS_SHUTDOWN = 2'b00,
      AMFS_BOOT = 2'b01,
      AMFS_RUN = 2'b10,
      AMFS_STANDBY = 2'b11
   } amfs_state_t;

   // monitor flags for one channel
   typedef struct packed {
      logic dc;
      logic fly;
      logic oc;
   } amfs_ch_flags_t;

   // per-channel drive to the output stage
   typedef struct packed {
      logic switching;
      logic mute;
      logic second_stage;
      logic fsw_tick;
   } amfs_stage_t;
endpackage : amfs_pkg

//--- amfs_channel.sv
module amfs_channel
   import amfs_pkg::*;
#(
   parameter int DC_LIMIT = DC_CYC,
   parameter int RESTART = RESTART_CYC
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic dc_i,
   input wire logic oc_i,
   output logic trip_o,
   output logic dc_evt_o,
   output logic oc_evt_o
);
   initial begin
      if (DC_LIMIT < 1 || RESTART < 1) begin
         $error("amfs_channel: counts must be positive");
      end
   end

   // -----------------------------------------------------------------
   // dc persistence, overcurrent trip and timed restart
   // -----------------------------------------------------------------
   logic [31:0] dc_cnt_reg, dc_cnt_next;
   logic [31:0] rs_cnt_reg, rs_cnt_next;
   logic trip_reg, trip_next;
   logic dc_evt_next, oc_evt_next;

   always_comb begin
      dc_cnt_next = dc_cnt_reg;
      rs_cnt_next = rs_cnt_reg;
      trip_next = trip_reg;
      dc_evt_next = 1'b0;
      oc_evt_next = 1'b0;
      if (trip_reg) begin
         dc_cnt_next = '0;
         if (rs_cnt_reg == 32'(RESTART - 1)) begin
            trip_next = 1'b0;
         end else begin
            rs_cnt_next = rs_cnt_reg + 32'h1;
         end
      end else if (oc_i) begin
         trip_next = 1'b1;
         oc_evt_next = 1'b1;
         rs_cnt_next = '0;
      end else if (dc_i) begin
         if (dc_cnt_reg == 32'(DC_LIMIT - 1)) begin
            trip_next = 1'b1;
            dc_evt_next = 1'b1;
            rs_cnt_next = '0;
         end else begin
            dc_cnt_next = dc_cnt_reg + 32'h1;
         end
      end else begin
         dc_cnt_next = '0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         dc_cnt_reg <= '0;
         rs_cnt_reg <= '0;
         trip_reg <= 1'b0;
         dc_evt_o <= 1'b0;
         oc_evt_o <= 1'b0;
      end else begin
         dc_cnt_reg <= dc_cnt_next;
         rs_cnt_reg <= rs_cnt_next;
         trip_reg <= trip_next;
         dc_evt_o <= dc_evt_next;
         oc_evt_o <= oc_evt_next;
      end
   end

   assign trip_o = trip_reg;

   a_oc_trips: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (!trip_reg && oc_i) |=> (trip_reg && oc_evt_o))
      else $error("overcurrent did not trip stage");
endmodule : amfs_channel

//--- amfs_supervisor.sv
// Notes on behaviour
// - shutdown while enable low, boot on rise
// - mute immediate, unmute after timed delay
// - channel mute bits, source select pin/bits
// - muted keeps balancing; off bit stops switching
// - standby lowest power, control stays alive
// - config pin picks parallel or two-channel
// - parallel bit overrides only with enable
// - parallel mode gates second stage by level
// - two-bit gain, reset default code 11
// - economy varies 128-256 kHz, fidelity fixed
// - threshold exceeded logs error, pulls line low
// - error line valid only after first lock
// - status bit mirrors error line level
// - seven general faults live and sticky
// - per-channel dc, fly, overcurrent sticky
// - clear sticky on 0-1-0 toggle
// - dc over 1 Hz period trips, restarts
// - overcurrent trips stage, restarts
// - overvoltage forces mute while its live flag is set
// - undervoltage mutes and stops switching
// - warning only flags; error stops switching
// - clock loss halts; audio error separate bit
// - fly fault mutes, ignored below 13 V
// - clip is status only, no fault
module amfs_supervisor
   import amfs_pkg::*;
#(
   parameter int BOOT = BOOT_CYC,
   parameter int UNMUTE = UNMUTE_CYC,
   parameter int DC_LIMIT = DC_CYC,
   parameter int RESTART = RESTART_CYC
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_i,
   input wire logic mute_input_low_active_i,
   input wire logic output_config_select_pin_i,
   input wire logic clip_indicator_pin_i,
   input wire logic standby_i,
   input wire logic mute_source_reg_i,
   input wire logic [1:0] channel_silence_bits_i,
   input wire logic [1:0] channel_off_bits_i,
   input wire logic parallel_bridge_i,
   input wire logic config_override_enable_i,
   input wire logic power_profile_i,
   input wire logic [1:0] gain_i,
   input wire logic gain_load_i,
   input wire logic fault_clear_toggle_i,
   input wire logic high_level_i,
   input wire logic pll_locked_i,
   input wire logic [GEN_W-1:0] gen_flag_i,
   input wire amfs_ch_flags_t [1:0] ch_flag_i,
   input wire logic pvdd_above_13v_i,
   output amfs_stage_t [1:0] stage_o,
   output logic fault_output_low_active_o,
   output logic fault_pin_status_o,
   output logic clip_status_o,
   output logic [GEN_W-1:0] live_fault_vector_o,
   output logic [GEN_W-1:0] sticky_fault_vector_o,
   output logic [CH_W-1:0] sticky_ch0_o,
   output logic [CH_W-1:0] sticky_ch1_o,
   output logic two_channel_bridge_output_o,
   output logic [1:0] gain_o,
   output logic [1:0] mode_o
);
   initial begin
      if (BOOT < 1 || UNMUTE < 1) begin
         $error("amfs_supervisor: counts must be positive");
      end
   end

   // -----------------------------------------------------------------
   // pin synchronisers
   // -----------------------------------------------------------------
   localparam int NSYNC = 6 + GEN_W + 2 * CH_W;
   logic [NSYNC-1:0] s1_reg, s2_reg;
   logic [NSYNC-1:0] raw;
   assign raw = {enable_i, mute_input_low_active_i,
                 output_config_select_pin_i, clip_indicator_pin_i,
                 pll_locked_i, pvdd_above_13v_i, gen_flag_i,
                 ch_flag_i[1], ch_flag_i[0]};
   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         s1_reg <= '0;
         s2_reg <= '0;
      end else begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
      end
   end
   logic en_s, mute_n_s, output_config_select_pin_s, clip_s, lock_s, hv_s;
   logic [GEN_W-1:0] gen_s;
   amfs_ch_flags_t [1:0] ch_s;
   assign {en_s, mute_n_s, output_config_select_pin_s, clip_s, lock_s, hv_s, gen_s,
           ch_s[1], ch_s[0]} = s2_reg;

   // -----------------------------------------------------------------
   // mode state machine
   // -----------------------------------------------------------------
   amfs_state_t st_reg, st_next;
   logic [31:0] boot_reg, boot_next;
   logic en_d_reg;
   always_comb begin
      st_next = st_reg;
      boot_next = boot_reg;
      case (st_reg)
         AMFS_SHUTDOWN: begin
            boot_next = '0;
            if (en_s && !en_d_reg) begin
               st_next = AMFS_BOOT;
            end
         end
         AMFS_BOOT: begin
            if (boot_reg == 32'(BOOT - 1)) begin
               st_next = AMFS_RUN;
            end else begin
               boot_next = boot_reg + 32'h1;
            end
         end
         AMFS_RUN: begin
            if (standby_i) begin
               st_next = AMFS_STANDBY;
            end
         end
         AMFS_STANDBY: begin
            if (!standby_i) begin
               st_next = AMFS_RUN;
            end
         end
         default: st_next = AMFS_SHUTDOWN;
      endcase
      if (!en_s) begin
         st_next = AMFS_SHUTDOWN;
      end
   end

   // -----------------------------------------------------------------
   // output configuration and gain
   // -----------------------------------------------------------------
   logic pin_par_reg, strap_done_reg;
   logic [1:0] gain_reg, gain_next;
   always_comb begin
      gain_next = gain_reg;
      if (gain_load_i) begin
         gain_next = gain_i;
      end
   end
   logic par_mode;
   // pin strap caught once at boot start, later pin moves ignored
   assign par_mode = config_override_enable_i ? parallel_bridge_i
                                              : pin_par_reg;

   // -----------------------------------------------------------------
   // per-channel protection and mute
   // -----------------------------------------------------------------
   logic [1:0] trip, dc_evt, oc_evt;
   logic [1:0] req_mute;
   logic [1:0] unmute_ok;
   logic [31:0] um_reg [2];
   logic [31:0] um_next [2];
   logic run, fault_mute, stop_all;
   assign run = (st_reg == AMFS_RUN);
   assign fault_mute = gen_s[GF_OVP] || gen_s[GF_UVP];
   assign stop_all = gen_s[GF_OTE] || gen_s[GF_PLL] || !run;

   genvar c;
   generate
      for (c = 0; c < 2; c++) begin : g_ch
         amfs_channel #(
            .DC_LIMIT(DC_LIMIT),
            .RESTART(RESTART)
         ) u_ch (
            .core_clk_i(core_clk_i),
            .sys_rst_i(sys_rst_i),
            .dc_i(ch_s[c].dc && run),
            .oc_i(ch_s[c].oc && run),
            .trip_o(trip[c]),
            .dc_evt_o(dc_evt[c]),
            .oc_evt_o(oc_evt[c])
         );
         assign req_mute[c] = mute_source_reg_i ? channel_silence_bits_i[c]
                              : !mute_n_s;
      end
   endgenerate

   always_comb begin
      for (int i = 0; i < 2; i++) begin
         um_next[i] = um_reg[i];
         if (req_mute[i]) begin
            um_next[i] = '0;
         end else if (um_reg[i] != 32'(UNMUTE)) begin
            um_next[i] = um_reg[i] + 32'h1;
         end
         unmute_ok[i] = (um_reg[i] == 32'(UNMUTE));
      end
   end

   // -----------------------------------------------------------------
   // switching rate divider
   // -----------------------------------------------------------------
   logic [15:0] div_reg, div_next;
   logic [15:0] div_max;
   logic tick;
   assign div_max = (power_profile_i && high_level_i) || !power_profile_i
                    ? 16'(FSW_HI_DIV - 1) : 16'(FSW_LO_DIV - 1);
   assign tick = (div_reg >= div_max);
   assign div_next = tick ? 16'h0 : div_reg + 16'h1;

   amfs_stage_t [1:0] stage_next;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         stage_next[i].switching = !stop_all && !trip[i] && !fault_mute
            && !channel_off_bits_i[i];
         stage_next[i].mute = req_mute[i] || !unmute_ok[i] || fault_mute
            || (ch_s[i].fly && hv_s);
         stage_next[i].second_stage = (i == 1) && (!par_mode
            || high_level_i);
         stage_next[i].fsw_tick = tick && stage_next[i].switching;
      end
   end

   // -----------------------------------------------------------------
   // fault vectors and error line
   // -----------------------------------------------------------------
   logic [GEN_W-1:0] live, sticky_reg, sticky_next;
   logic [CH_W-1:0] sch_reg [2];
   logic [CH_W-1:0] sch_next [2];
   logic clr_d_reg, clr_pulse, locked_once_reg;
   assign clr_pulse = clr_d_reg && !fault_clear_toggle_i;
   assign live = gen_s;
   always_comb begin
      sticky_next = (clr_pulse ? '0 : sticky_reg) | live;
      for (int i = 0; i < 2; i++) begin
         sch_next[i] = (clr_pulse ? '0 : sch_reg[i])
            | {oc_evt[i], ch_s[i].fly && hv_s, dc_evt[i]};
      end
   end
   logic any_sticky;
   assign any_sticky = (|sticky_reg) || (|sch_reg[0]) || (|sch_reg[1]);
   logic err_n_next;
   // line reports low only once the clock has first locked
   assign err_n_next = !(locked_once_reg && any_sticky);

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         st_reg <= AMFS_SHUTDOWN;
         boot_reg <= '0;
         en_d_reg <= 1'b0;
         pin_par_reg <= 1'b0;
         strap_done_reg <= 1'b0;
         gain_reg <= GAIN_RST;
         um_reg[0] <= '0;
         um_reg[1] <= '0;
         div_reg <= '0;
         stage_o <= '0;
         sticky_reg <= '0;
         sch_reg[0] <= '0;
         sch_reg[1] <= '0;
         clr_d_reg <= 1'b0;
         locked_once_reg <= 1'b0;
         fault_output_low_active_o <= 1'b1;
         fault_pin_status_o <= 1'b1;
         clip_status_o <= 1'b0;
         live_fault_vector_o <= '0;
         two_channel_bridge_output_o <= 1'b1;
         mode_o <= AMFS_SHUTDOWN;
      end else begin
         st_reg <= st_next;
         boot_reg <= boot_next;
         en_d_reg <= en_s;
         if (!strap_done_reg && st_next == AMFS_BOOT) begin
            pin_par_reg <= !output_config_select_pin_s;
            strap_done_reg <= 1'b1;
         end
         gain_reg <= gain_next;
         um_reg[0] <= um_next[0];
         um_reg[1] <= um_next[1];
         div_reg <= div_next;
         stage_o <= stage_next;
         sticky_reg <= sticky_next;
         sch_reg[0] <= sch_next[0];
         sch_reg[1] <= sch_next[1];
         clr_d_reg <= fault_clear_toggle_i;
         locked_once_reg <= locked_once_reg || lock_s;
         fault_output_low_active_o <= err_n_next;
         fault_pin_status_o <= fault_output_low_active_o;
         clip_status_o <= !clip_s;
         live_fault_vector_o <= live;
         two_channel_bridge_output_o <= !par_mode;
         mode_o <= st_reg;
      end
   end

   assign sticky_fault_vector_o = sticky_reg;
   assign sticky_ch0_o = sch_reg[0];
   assign sticky_ch1_o = sch_reg[1];
   assign gain_o = gain_reg;

   a_err_follows: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (locked_once_reg && any_sticky) |=> !fault_output_low_active_o)
      else $error("error line not asserted");
   a_ovp_mutes: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      gen_s[GF_OVP] |=> (stage_o[0].mute && !stage_o[0].switching))
      else $error("overvoltage did not mute");
   a_shutdown_low: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !en_s |=> (st_reg == AMFS_SHUTDOWN))
      else $error("not in shutdown");
   a_pin_mirror: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      ##1 fault_pin_status_o == $past(fault_output_low_active_o))
      else $error("status not mirroring line");
   a_clear_works: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      (clr_pulse && live == '0) |=> sticky_reg == '0)
      else $error("sticky not cleared");
   a_no_err_unlock: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      !locked_once_reg |=> fault_output_low_active_o)
      else $error("error before first lock");
   a_off_stops: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      channel_off_bits_i[1] |=> !stage_o[1].switching)
      else $error("off channel switching");
   a_ote_stops: assert property (
      @(posedge core_clk_i) disable iff (sys_rst_i)
      gen_s[GF_OTE] |=> !stage_o[1].switching)
      else $error("overheat did not stop");
endmodule : amfs_supervisor

//--- amfs_host_model.sv
module amfs_host_model
   import amfs_pkg::*;
#(
   parameter int STARTUP = 16
) (
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic en_req_i,
   input wire logic mute_req_i,
   input wire logic clr_req_i,
   input wire logic fault_output_low_active_i,
   output logic enable_o,
   output logic mute_input_low_active_o,
   output logic fault_clear_toggle_o,
   output logic fault_seen_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int start_cnt;
   int clr_cnt;
   // ----------------------------------------------------------------
   // host pin drive and fault handling
   // ----------------------------------------------------------------
   always @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         enable_o <= 1'b0;
         mute_input_low_active_o <= 1'b1;
         fault_clear_toggle_o <= 1'b0;
         fault_seen_o <= 1'b0;
         start_cnt <= 0;
         clr_cnt <= 0;
      end else begin
         enable_o <= en_req_i;
         mute_input_low_active_o <= ~mute_req_i;
         if (!enable_o) begin
            start_cnt <= 0;
         end else if (start_cnt < STARTUP) begin
            start_cnt <= start_cnt + 1;
         end
         // clear once start-up is over, and again on request
         if (clr_req_i || start_cnt == STARTUP - 1) begin
            clr_cnt <= 4;
         end else if (clr_cnt != 0) begin
            clr_cnt <= clr_cnt - 1;
         end
         fault_clear_toggle_o <= (clr_cnt > 1);
         // faults during start-up are disregarded
         fault_seen_o <= (start_cnt == STARTUP) &&
            !fault_output_low_active_i;
      end
   end
endmodule : amfs_host_model

//--- tb.sv
module tb
   import amfs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int UNM = 8;
   localparam int DCL = 16;
   logic clk = 1'b0, rst = 1'b1, en_req = 1'b0, mute_req = 1'b0;
   logic clr_req = 1'b0, standby = 1'b0, msrc = 1'b0, pb = 1'b0;
   logic ovr = 1'b0, prof = 1'b0, gload = 1'b0, hl = 1'b0, lock = 1'b0;
   logic p13 = 1'b0, clip_n = 1'b1, output_config_select_pin = 1'b1;
   logic [1:0] silence = 2'h0, off = 2'h0, gain = 2'h0;
   logic [GEN_W-1:0] gen = '0;
   amfs_ch_flags_t [1:0] chf = '0;
   amfs_stage_t [1:0] stage;
   logic fault_n, fstat, clip_st, two_ch, en, mute_n, fclr, fseen;
   logic [GEN_W-1:0] live, sticky;
   logic [CH_W-1:0] s0, s1;
   logic [1:0] gain_q, mode;
   logic [31:0] seed = 32'h4a82;
   int errors = 0;
   int n_compared = 0;
   int k;
   int n;
   // ----------------------------------------------------------------
   // clock, design and host
   // ----------------------------------------------------------------
   initial begin
      forever #2.5 clk = ~clk;
   end
   amfs_host_model u_host (.core_clk_i(clk), .sys_rst_i(rst),
      .en_req_i(en_req), .mute_req_i(mute_req), .clr_req_i(clr_req),
      .fault_output_low_active_i(fault_n), .enable_o(en),
      .mute_input_low_active_o(mute_n), .fault_clear_toggle_o(fclr),
      .fault_seen_o(fseen));
   // config pin fixed before each power-up
   amfs_supervisor #(.BOOT(8), .UNMUTE(UNM), .DC_LIMIT(DCL), .RESTART(8))
   u_dut (.core_clk_i(clk), .sys_rst_i(rst), .enable_i(en),
      .mute_input_low_active_i(mute_n), .output_config_select_pin_i(output_config_select_pin),
      .clip_indicator_pin_i(clip_n), .standby_i(standby),
      .mute_source_reg_i(msrc), .channel_silence_bits_i(silence),
      .channel_off_bits_i(off), .parallel_bridge_i(pb),
      .config_override_enable_i(ovr), .power_profile_i(prof),
      .gain_i(gain), .gain_load_i(gload), .fault_clear_toggle_i(fclr),
      .high_level_i(hl), .pll_locked_i(lock), .gen_flag_i(gen),
      .ch_flag_i(chf), .pvdd_above_13v_i(p13), .stage_o(stage),
      .fault_output_low_active_o(fault_n), .fault_pin_status_o(fstat),
      .clip_status_o(clip_st), .live_fault_vector_o(live),
      .sticky_fault_vector_o(sticky), .sticky_ch0_o(s0),
      .sticky_ch1_o(s1), .two_channel_bridge_output_o(two_ch),
      .gain_o(gain_q), .mode_o(mode));
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   function automatic logic exp_two(logic pin, logic par, logic ov);
      return ov ? ~par : pin;
   endfunction : exp_two
   task automatic cyc(input int c);
      repeat (c) @(posedge clk);
   endtask : cyc
   task automatic look();
      @(negedge clk);
   endtask : look
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
         input string m);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got,
            exp);
      end
   endtask : chk
   task automatic clear_faults();
      cyc(1);
      clr_req <= 1'b1;
      cyc(1);
      clr_req <= 1'b0;
      cyc(12);
      look();
   endtask : clear_faults
   task automatic wait_mode(input logic [1:0] m);
      for (k = 0; k < 200 && mode !== m; k++) begin
         cyc(1);
      end
      look();
   endtask : wait_mode
   task automatic ticks();
      n = 0;
      repeat (3124) begin
         look();
         if (stage[0].fsw_tick === 1'b1) n++;
      end
   endtask : ticks
   task automatic pulse_ch(input int ch, input int kind, input int len);
      cyc(1);
      chf <= 6'h1 << (ch * 3 + 2 - kind);
      cyc(len);
      chf <= '0;
      cyc(10);
      look();
   endtask : pulse_ch
   task give_verdict();
      if (errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : give_verdict
   initial begin
      repeat (40000) @(posedge clk);
      errors++;
      give_verdict();
   end
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   initial begin
      cyc(5);
      rst <= 1'b0;
      look();
      chk(gain_q, GAIN_RST, "gain reset");
      chk(mode, AMFS_SHUTDOWN, "mode reset");
      chk(two_ch, exp_two(1'b1, 1'b0, 1'b0), "pin config");
      cyc(1);
      gen <= 7'h1 << GF_LOWTEMP;
      cyc(8);
      look();
      chk(fault_n, 1'b1, "error before lock");
      cyc(1);
      gen <= '0;
      clear_faults();
      cyc(1);
      lock <= 1'b1;
      en_req <= 1'b1;
      wait_mode(AMFS_RUN);
      chk(mode, AMFS_RUN, "boot to run");
      cyc(UNM + 30);
      mute_req <= 1'b1;
      cyc(6);
      look();
      chk(stage[0].mute, 1'b1, "pin mute");
      chk(stage[1].switching, 1'b1, "muted switching");
      cyc(1);
      mute_req <= 1'b0;
      cyc(4);
      look();
      chk(stage[0].mute, 1'b1, "unmute delayed");
      cyc(UNM + 12);
      look();
      chk(stage[0].mute, 1'b0, "unmuted");
      cyc(1);
      msrc <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         silence <= (i == 4) ? 2'h0 : 2'(xs());
         mute_req <= (i == 4);
         cyc(UNM + 12);
         look();
         chk({stage[1].mute, stage[0].mute}, silence, "bit mute");
         cyc(1);
      end
      mute_req <= 1'b0;
      msrc <= 1'b0;
      off <= 2'h2;
      cyc(6);
      look();
      chk({stage[1].switching, stage[0].switching}, 2'h1, "off");
      for (int i = 0; i < 6; i++) begin
         cyc(1);
         off <= 2'h0;
         gain <= (i < 4) ? 2'(i) : 2'(xs());
         gload <= 1'b1;
         cyc(1);
         gload <= 1'b0;
         cyc(4);
         look();
         chk(gain_q, gain, "gain code");
      end
      ticks();
      chk(n >= 3 && n <= 5, 1'b1, "fidelity rate");
      cyc(1);
      prof <= 1'b1;
      pb <= 1'b1;
      cyc(6);
      look();
      chk(two_ch, exp_two(1'b1, 1'b1, 1'b0), "no override");
      cyc(1);
      ovr <= 1'b1;
      cyc(6);
      look();
      chk(two_ch, exp_two(1'b1, 1'b1, 1'b1), "override");
      chk(stage[1].second_stage, 1'b0, "second idle");
      ticks();
      chk(n >= 1 && n <= 3, 1'b1, "economy rate");
      cyc(1);
      hl <= 1'b1;
      cyc(6);
      look();
      chk(stage[1].second_stage, 1'b1, "second active");
      cyc(1);
      {ovr, pb, prof, hl} <= 4'h0;
      for (int i = 0; i < GEN_W; i++) begin
         cyc(UNM + 12);
         gen <= 7'h1 << i;
         cyc(8);
         look();
         chk(live, 7'h1 << i, "live vector");
         chk(fault_n, 1'b0, "error line");
         chk(fstat, 1'b0, "error status");
         chk(fseen, 1'b1, "host saw error");
         if (i == GF_OVP || i == GF_UVP)
            chk(stage[0].mute, 1'b1, "supply mute");
         if (i == GF_OTE)
            chk(stage[1].switching, 1'b0, "heat stop");
         if (i == GF_OTW)
            chk(stage[0].mute, 1'b0, "warn only");
         cyc(1);
         gen <= '0;
         cyc(8);
         look();
         chk(sticky, 7'h1 << i, "sticky vector");
         chk(fault_n, 1'b0, "error held");
         clear_faults();
         chk(sticky, 7'h0, "sticky cleared");
         chk(fault_n, 1'b1, "error released");
      end
      pulse_ch(0, CF_OC, 6);
      chk(s0, 3'h1 << CF_OC, "oc sticky");
      chk(s1, 3'h0, "other channel");
      clear_faults();
      pulse_ch(1, CF_DC, DCL / 2);
      chk(s1, 3'h0, "short dc");
      pulse_ch(1, CF_DC, DCL + 12);
      chk(s1, 3'h1 << CF_DC, "long dc");
      clear_faults();
      pulse_ch(0, CF_FLY, 10);
      chk(s0, 3'h0, "fly below 13v");
      cyc(1);
      p13 <= 1'b1;
      chf[0].fly <= 1'b1;
      cyc(8);
      look();
      chk(stage[0].mute, 1'b1, "fly mute");
      pulse_ch(0, CF_FLY, 1);
      chk(s0, 3'h1 << CF_FLY, "fly sticky");
      chk(stage[0].mute, 1'b0, "fly unmute");
      clear_faults();
      cyc(1);
      clip_n <= 1'b0;
      cyc(6);
      look();
      chk(clip_st, 1'b1, "clip status");
      chk(fault_n, 1'b1, "clip no error");
      cyc(1);
      clip_n <= 1'b1;
      standby <= 1'b1;
      wait_mode(AMFS_STANDBY);
      chk(mode, AMFS_STANDBY, "standby");
      cyc(1);
      standby <= 1'b0;
      en_req <= 1'b0;
      wait_mode(AMFS_SHUTDOWN);
      chk(mode, AMFS_SHUTDOWN, "shutdown");
      // second power-up with the config pin tied for parallel output
      cyc(1);
      output_config_select_pin <= 1'b0;
      rst <= 1'b1;
      cyc(5);
      rst <= 1'b0;
      en_req <= 1'b1;
      look();
      chk(gain_q, GAIN_RST, "gain after reset");
      wait_mode(AMFS_RUN);
      chk(mode, AMFS_RUN, "second boot");
      chk(two_ch, exp_two(1'b0, 1'b0, 1'b0), "pin parallel");
      give_verdict();
   end
endmodule : tb
